/* File: hw/pin_function_mux_power_gating.sv */
// Purpose: pin function multiplexer with emulated runtime power gating
// Assumes: avalon-mm slave, byte addresses, one register per pin
// Notes:   pad and core-side results are registered, one cycle latency
`timescale 1ns/1ps
module pin_function_mux_power_gating (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        main_power_good_in,
	input  wire logic [7:0]  pad_in,
	output logic [7:0]       pad_out,
	output logic [7:0]       pad_oe,
	input  wire logic        host_power_down_pad_in,
	output logic             host_power_down_n,
	input  wire logic        led0_out,
	input  wire logic        test_clk_out,
	input  wire logic        smbus_port0_data_drive,
	input  wire logic        smbus_port0_data_low_volt_drive,
	output logic             smbus_port0_data,
	output logic             smbus_port0_data_low_volt,
	output logic             kbd_scan_input_2,
	input  wire logic        smbus_port0_clock_drive,
	input  wire logic        smbus_port0_clock_low_volt_drive,
	output logic             smbus_port0_clock,
	output logic             smbus_port0_clock_low_volt,
	output logic             kbd_scan_input_3,
	output logic             external_reset_input_n,
	input  wire logic        kbd_scan_output_3,
	input  wire logic        private_flash_data0_out,
	input  wire logic        private_flash_data0_oe,
	output logic             private_flash_data0,
	output logic             fan_tach_0,
	input  wire logic        pwm_0,
	output logic             uart_baud_clock
);

	localparam int N = pinmux_pkg::NUM_PINS;

	typedef struct packed {
		logic [N-1:0][pinmux_pkg::CTRL_W-1:0] ctrl;
		logic                                 waitrequest;
		logic [pinmux_pkg::DATA_W-1:0]        readdata;
		logic [N-1:0]                         pad_out;
		logic [N-1:0]                         pad_oe;
		logic [N-1:0][2:0]                    alt_in;
		logic                                 host_power_down_n;
	} state_t;

	state_t st;
	state_t next_st;

	logic [N-1:0][2:0] alt_out;
	logic [N-1:0][2:0] alt_oe;
	logic [N-1:0]      slice_out;
	logic [N-1:0]      slice_oe;
	logic [N-1:0][2:0] slice_in;
	logic              fixed_value;
	logic [N-1:0][pinmux_pkg::SEL_W-1:0] sel_of;

	// peripheral outputs per pin, bit k is alternate k+1
	// smbus lines are open drain: pad low while the core pulls
	assign alt_out[pinmux_pkg::PIN_LED] =
		{pinmux_pkg::OD_LOW, test_clk_out, led0_out};
	assign alt_oe[pinmux_pkg::PIN_LED] =
		{pinmux_pkg::DRIVE_OFF, pinmux_pkg::DRIVE_ON, pinmux_pkg::DRIVE_ON};
	assign alt_out[pinmux_pkg::PIN_SMB_DATA] = '0;
	assign alt_oe[pinmux_pkg::PIN_SMB_DATA] = {pinmux_pkg::DRIVE_OFF,
		smbus_port0_data_low_volt_drive, smbus_port0_data_drive};
	assign alt_out[pinmux_pkg::PIN_SMB_CLK] = '0;
	assign alt_oe[pinmux_pkg::PIN_SMB_CLK] = {pinmux_pkg::DRIVE_OFF,
		smbus_port0_clock_low_volt_drive, smbus_port0_clock_drive};
	assign alt_out[pinmux_pkg::PIN_RESET] = '0;
	assign alt_oe[pinmux_pkg::PIN_RESET] = '0;
	assign alt_out[pinmux_pkg::PIN_FLASH] =
		{pinmux_pkg::OD_LOW, private_flash_data0_out, kbd_scan_output_3};
	assign alt_oe[pinmux_pkg::PIN_FLASH] =
		{pinmux_pkg::DRIVE_OFF, private_flash_data0_oe, pinmux_pkg::DRIVE_ON};
	assign alt_out[pinmux_pkg::PIN_TACH] = '0;
	assign alt_oe[pinmux_pkg::PIN_TACH] = '0;
	assign alt_out[pinmux_pkg::PIN_PWM] =
		{pinmux_pkg::OD_LOW, pinmux_pkg::OD_LOW, pwm_0};
	assign alt_oe[pinmux_pkg::PIN_PWM] =
		{pinmux_pkg::DRIVE_OFF, pinmux_pkg::DRIVE_OFF, pinmux_pkg::DRIVE_ON};
	// comparator reference on this pin is analog, no digital path here
	assign alt_out[pinmux_pkg::PIN_UART] = '0;
	assign alt_oe[pinmux_pkg::PIN_UART] = '0;

	for (genvar i = 0; i < N; i++)
	begin : g_pin
		assign sel_of[i] =
			st.ctrl[i][pinmux_pkg::CTRL_SEL_LSB +: pinmux_pkg::SEL_W];
		pin_slice #(
			.KINDS   (pinmux_pkg::KIND_TABLE[i]),
			.GATES   (pinmux_pkg::GATE_TABLE[i]),
			.UNGATED (pinmux_pkg::UNGATED_TABLE[i])
		) u_slice (
			.sel        (st.ctrl[i][pinmux_pkg::CTRL_SEL_LSB +:
				pinmux_pkg::SEL_W]),
			.pwr_gate   (st.ctrl[i][pinmux_pkg::CTRL_PWR_GATE]),
			.power_good (main_power_good_in),
			.gpio_oe    (st.ctrl[i][pinmux_pkg::CTRL_DIR_OUT]),
			.gpio_od    (st.ctrl[i][pinmux_pkg::CTRL_OPEN_DRAIN]),
			.gpio_data  (st.ctrl[i][pinmux_pkg::CTRL_OUT_DATA]),
			.alt_out    (alt_out[i]),
			.alt_oe     (alt_oe[i]),
			.pad_in     (pad_in[i]),
			.pad_out    (slice_out[i]),
			.pad_oe     (slice_oe[i]),
			.alt_in     (slice_in[i])
		);
	end

	fixed_input_pin #(
		.EMULATE_VCC (pinmux_pkg::EMULATE_ON),
		.GATE        (pinmux_pkg::GATE_HIGH)
	) u_fixed (
		.pad_in     (host_power_down_pad_in),
		.power_good (main_power_good_in),
		.value      (fixed_value)
	);

	always_comb
	begin
		logic [5:0]                    word;
		logic [pinmux_pkg::DATA_W-1:0] rd;
		next_st = st;
		word    = address[pinmux_pkg::WORD_LSB +: 6];
		rd      = '0;
		// read mux: pin control words, then status, else zero
		if (address >= pinmux_pkg::PIN_CTRL_BASE &&
			word < 6'(N))
		begin
			rd[pinmux_pkg::CTRL_W-1:0] = st.ctrl[word[2:0]];
			rd[pinmux_pkg::PIN_LEVEL_BIT] = pad_in[word[2:0]];
		end
		else if (address == pinmux_pkg::STATUS_ADDR)
		begin
			rd[pinmux_pkg::STATUS_PG_BIT] = main_power_good_in;
		end
		// one wait cycle, then the answer; write lands at the end of the answer cycle
		if ((read || write) && st.waitrequest)
		begin
			next_st.waitrequest = 1'b0;
			next_st.readdata    = rd;
		end
		else
		begin
			next_st.waitrequest = 1'b1;
		end
		if (write && !st.waitrequest && byteenable[0] &&
			word < 6'(N))
		begin
			// software reprograms select, gating, direction, drive
			next_st.ctrl[word[2:0]] =
				writedata[pinmux_pkg::CTRL_W-1:0];
		end
		next_st.pad_out           = slice_out;
		next_st.pad_oe            = slice_oe;
		next_st.alt_in            = slice_in;
		next_st.host_power_down_n = fixed_value;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st                   <= '0;
			st.ctrl              <= pinmux_pkg::CTRL_RESET;
			st.waitrequest       <= 1'b1;
			// core inputs wake at their gated levels, no false edge later
			st.alt_in            <= pinmux_pkg::GATE_TABLE;
			st.host_power_down_n <= pinmux_pkg::GATE_HIGH;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign readdata                   = st.readdata;
	assign waitrequest                = st.waitrequest;
	assign pad_out                    = st.pad_out;
	assign pad_oe                     = st.pad_oe;
	assign host_power_down_n          = st.host_power_down_n;
	assign smbus_port0_data           = st.alt_in[pinmux_pkg::PIN_SMB_DATA][0];
	assign smbus_port0_data_low_volt  = st.alt_in[pinmux_pkg::PIN_SMB_DATA][1];
	assign kbd_scan_input_2           = st.alt_in[pinmux_pkg::PIN_SMB_DATA][2];
	assign smbus_port0_clock          = st.alt_in[pinmux_pkg::PIN_SMB_CLK][0];
	assign smbus_port0_clock_low_volt = st.alt_in[pinmux_pkg::PIN_SMB_CLK][1];
	assign kbd_scan_input_3           = st.alt_in[pinmux_pkg::PIN_SMB_CLK][2];
	assign external_reset_input_n     = st.alt_in[pinmux_pkg::PIN_RESET][0];
	assign private_flash_data0        = st.alt_in[pinmux_pkg::PIN_FLASH][1];
	assign fan_tach_0                 = st.alt_in[pinmux_pkg::PIN_TACH][0];
	assign uart_baud_clock            = st.alt_in[pinmux_pkg::PIN_UART][1];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_gate_tristate: assert property (
		(!main_power_good_in &&
		st.ctrl[pinmux_pkg::PIN_PWM][pinmux_pkg::CTRL_PWR_GATE])
		|=> !pad_oe[pinmux_pkg::PIN_PWM])
		else $error("emulated output drove pad without power good");

	a_smbus_gate_high: assert property (
		(sel_of[pinmux_pkg::PIN_SMB_CLK] != pinmux_pkg::SEL_ALT1 ||
		(!main_power_good_in &&
		st.ctrl[pinmux_pkg::PIN_SMB_CLK][pinmux_pkg::CTRL_PWR_GATE]))
		|=> smbus_port0_clock)
		else $error("gated smbus clock input not high");

	a_smbus_lv_high: assert property (
		(sel_of[pinmux_pkg::PIN_SMB_CLK] != pinmux_pkg::SEL_ALT2)
		|=> smbus_port0_clock_low_volt)
		else $error("gated low voltage smbus clock not high");

	a_smbus_data_high: assert property (
		(sel_of[pinmux_pkg::PIN_SMB_DATA] != pinmux_pkg::SEL_ALT1)
		|=> smbus_port0_data)
		else $error("gated smbus data input not high");

	a_unselected_gate: assert property (
		(st.ctrl[pinmux_pkg::PIN_TACH][1:0] != pinmux_pkg::SEL_ALT1)
		|=> !fan_tach_0)
		else $error("unselected tach input not at gated level");

	a_selected_follow: assert property (
		(st.ctrl[pinmux_pkg::PIN_TACH][1:0] == pinmux_pkg::SEL_ALT1 &&
		!st.ctrl[pinmux_pkg::PIN_TACH][pinmux_pkg::CTRL_PWR_GATE])
		|=> fan_tach_0 == $past(pad_in[pinmux_pkg::PIN_TACH]))
		else $error("selected tach input does not follow pad");

	a_reset_pin_gate: assert property (
		(st.ctrl[pinmux_pkg::PIN_RESET][1:0] != pinmux_pkg::SEL_ALT1 ||
		(!main_power_good_in &&
		st.ctrl[pinmux_pkg::PIN_RESET][pinmux_pkg::CTRL_PWR_GATE]))
		|=> external_reset_input_n)
		else $error("gated reset input not held high");

	a_fixed_pin_gate: assert property (
		!main_power_good_in |=> host_power_down_n)
		else $error("dedicated input not gated high");

	a_reserved_quiet: assert property (
		(st.ctrl[pinmux_pkg::PIN_PWM][1:0] == pinmux_pkg::SEL_ALT3)
		|=> !pad_oe[pinmux_pkg::PIN_PWM])
		else $error("reserved select drove the pad");

	a_open_drain: assert property (
		(st.ctrl[pinmux_pkg::PIN_LED][1:0] == pinmux_pkg::SEL_GPIO &&
		st.ctrl[pinmux_pkg::PIN_LED][pinmux_pkg::CTRL_OPEN_DRAIN] &&
		st.ctrl[pinmux_pkg::PIN_LED][pinmux_pkg::CTRL_OUT_DATA])
		|=> !pad_oe[pinmux_pkg::PIN_LED])
		else $error("open drain pin drove a high level");

	a_flash_gate_low: assert property (
		(!main_power_good_in &&
		st.ctrl[pinmux_pkg::PIN_FLASH][pinmux_pkg::CTRL_PWR_GATE])
		|=> !private_flash_data0)
		else $error("gated flash data input not low");

	a_uart_gate_low: assert property (
		(sel_of[pinmux_pkg::PIN_UART] != pinmux_pkg::SEL_ALT2)
		|=> !uart_baud_clock)
		else $error("unselected uart clock input not low");

	a_push_pull: assert property (
		(sel_of[pinmux_pkg::PIN_LED] == pinmux_pkg::SEL_GPIO &&
		!st.ctrl[pinmux_pkg::PIN_LED][pinmux_pkg::CTRL_OPEN_DRAIN])
		|=> pad_out[pinmux_pkg::PIN_LED] ==
		$past(st.ctrl[pinmux_pkg::PIN_LED][pinmux_pkg::CTRL_OUT_DATA]))
		else $error("push-pull gpio pad level differs from data bit");

	a_bus_answer: assert property (
		((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not exactly one cycle after request");

	c_gpio_write: cover property (write && !waitrequest && byteenable[0]);
	c_power_drop: cover property (main_power_good_in ##1 !main_power_good_in);
	c_smbus_sel: cover property (
		st.ctrl[pinmux_pkg::PIN_SMB_CLK][1:0] == pinmux_pkg::SEL_ALT1);
	c_reserved_sel: cover property (
		sel_of[pinmux_pkg::PIN_PWM] == pinmux_pkg::SEL_ALT3);
	c_gated_input: cover property (!main_power_good_in &&
		st.ctrl[pinmux_pkg::PIN_FLASH][pinmux_pkg::CTRL_PWR_GATE]);

endmodule

/* File: hw/pinmux_pkg.sv */
// Purpose: shared constants and types for the pin function multiplexer
// Assumes: byte addressed register bus, one 32-bit word per register
// Notes:   pin tables give per-pin function kinds, gate levels and reset
package pinmux_pkg;

	localparam int NUM_PINS = 8;
	localparam int SEL_W    = 2;
	localparam int CTRL_W   = 6;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;

	typedef enum logic [1:0]
	{
		FK_NONE  = 2'h0,
		FK_IN    = 2'h1,
		FK_OUT   = 2'h2,
		FK_BIDIR = 2'h3
	} func_kind_t;

	// pin control and status register fields
	localparam int CTRL_SEL_LSB    = 0;
	localparam int CTRL_PWR_GATE   = 2;
	localparam int CTRL_DIR_OUT    = 3;
	localparam int CTRL_OPEN_DRAIN = 4;
	localparam int CTRL_OUT_DATA   = 5;
	localparam int PIN_LEVEL_BIT   = 8;
	localparam int STATUS_PG_BIT   = 0;

	localparam logic [ADDR_W-1:0] PIN_CTRL_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_ADDR   = 8'h40;
	localparam int                WORD_LSB      = 2;

	localparam logic [SEL_W-1:0] SEL_GPIO = 2'h0;
	localparam logic [SEL_W-1:0] SEL_ALT1 = 2'h1;
	localparam logic [SEL_W-1:0] SEL_ALT2 = 2'h2;
	localparam logic [SEL_W-1:0] SEL_ALT3 = 2'h3;

	// pin slots
	localparam int PIN_LED      = 0;
	localparam int PIN_SMB_DATA = 1;
	localparam int PIN_SMB_CLK  = 2;
	localparam int PIN_RESET    = 3;
	localparam int PIN_FLASH    = 4;
	localparam int PIN_TACH     = 5;
	localparam int PIN_PWM      = 6;
	localparam int PIN_UART     = 7;

	// function kinds per pin: alt1 in [1:0], alt2 in [3:2], alt3 in [5:4]
	localparam logic [NUM_PINS-1:0][5:0] KIND_TABLE = {
		6'h04, 6'h02, 6'h01, 6'h0e, 6'h01, 6'h1f, 6'h1f, 6'h0a
	};
	// gated level per alternate input, bit k for alt k+1
	localparam logic [NUM_PINS-1:0][2:0] GATE_TABLE = {
		3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h3, 3'h3, 3'h0
	};
	localparam logic [NUM_PINS-1:0][2:0] UNGATED_TABLE = {
		3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0
	};
	localparam logic [NUM_PINS-1:0][CTRL_W-1:0] CTRL_RESET = {
		6'h00, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00, 6'h00
	};

	localparam logic OD_LOW    = 1'b0;
	localparam logic DRIVE_ON  = 1'b1;
	localparam logic DRIVE_OFF = 1'b0;
	localparam logic GATE_HIGH = 1'b1;
	localparam logic EMULATE_ON = 1'b1;

endpackage

/* File: hw/pin_slice.sv */
// Purpose: one multiplexed pin, selects gpio or one of three alternates
// Assumes: select and control bits come from the pin control register
// Notes:   purely combinational, the top registers every result
`timescale 1ns/1ps
module pin_slice #(
	parameter logic [5:0] KINDS   = 6'h00,
	parameter logic [2:0] GATES   = 3'h0,
	parameter logic [2:0] UNGATED = 3'h0
)(
	input  wire logic [1:0] sel,
	input  wire logic       pwr_gate,
	input  wire logic       power_good,
	input  wire logic       gpio_oe,
	input  wire logic       gpio_od,
	input  wire logic       gpio_data,
	input  wire logic [2:0] alt_out,
	input  wire logic [2:0] alt_oe,
	input  wire logic       pad_in,
	output logic            pad_out,
	output logic            pad_oe,
	output logic [2:0]      alt_in
);

	always_comb
	begin
		logic                   domain_on;
		logic [1:0]             idx;
		pinmux_pkg::func_kind_t kind;
		pinmux_pkg::func_kind_t kind_k;
		domain_on = !pwr_gate || power_good;
		idx       = sel - pinmux_pkg::SEL_ALT1;
		kind      = pinmux_pkg::func_kind_t'(KINDS[2*idx +: 2]);
		kind_k    = pinmux_pkg::FK_NONE;
		pad_out   = pinmux_pkg::OD_LOW;
		pad_oe    = pinmux_pkg::DRIVE_OFF;
		if (sel == pinmux_pkg::SEL_GPIO)
		begin
			// gpio buffer type follows the control bits
			if (gpio_od)
			begin
				pad_oe = gpio_oe && !gpio_data && domain_on;
			end
			else
			begin
				pad_out = gpio_data;
				pad_oe  = gpio_oe && domain_on;
			end
		end
		else if (kind == pinmux_pkg::FK_OUT || kind == pinmux_pkg::FK_BIDIR)
		begin
			// alternate decides its own buffer type
			pad_out = alt_out[idx];
			pad_oe  = alt_oe[idx] && domain_on;
		end
		// reserved entries leave the pad undriven
		for (int k = 0; k < 3; k++)
		begin
			kind_k = pinmux_pkg::func_kind_t'(KINDS[2*k +: 2]);
			// gate level only reaches the core side, never the pad
			if (sel == SEL_W_K(k) && kind_k[0] && (domain_on || UNGATED[k]))
				alt_in[k] = pad_in;
			else
				alt_in[k] = GATES[k];
		end
	end

	function automatic logic [1:0] SEL_W_K(input int k);
		SEL_W_K = 2'(k + 1);
	endfunction

endmodule

/* File: hw/fixed_input_pin.sv */
// Purpose: dedicated input pin with no gpio and no select
// Assumes: emulated domain fixed at build time
// Notes:   no register can change its gating
`timescale 1ns/1ps
module fixed_input_pin #(
	parameter logic EMULATE_VCC = 1'b1,
	parameter logic GATE        = 1'b1
)(
	input  wire logic pad_in,
	input  wire logic power_good,
	output logic      value
);

	always_comb
	begin
		if (!EMULATE_VCC || power_good)
			value = pad_in;
		else
			value = GATE;
	end

endmodule

/* File: bench/pad_board_model.sv */
// Purpose: board side of the eight pads, pull-ups plus board drivers
// Assumes: every pad has a board pull-up, so a released pad reads high
// Notes:   wired-and; chip and board may both pull a line low
`timescale 1ns/1ps
module pad_board_model (
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] board_drive,
	input  wire logic [7:0] board_level,
	output logic [7:0]      pad_level
);
	// a released line never keeps its last value: the pull-up wins
	always_comb
	begin
		pad_level = (pad_out | ~pad_oe) & (board_level | ~board_drive);
	end
endmodule

/* File: bench/tb_pin_function_mux_power_gating.sv */
// Purpose: self-checking bench for the pin function multiplexer
// Assumes: one bus request at a time, board pull-ups on all pads
// Notes:   expectations come from bench functions, never from the design
`timescale 1ns/1ps
module tb_pin_function_mux_power_gating;
	logic             ref_clk = 1'h0;
	logic             rst = 1'h1;
	logic [7:0]       address = 8'h00;
	logic             read = 1'h0;
	logic             write = 1'h0;
	logic [3:0]       byteenable = 4'h0;
	logic [31:0]      writedata = 32'h0;
	logic [31:0]      readdata;
	logic             waitrequest;
	logic             pg = 1'h1;
	logic             hp_pad = 1'h0;
	logic [9:0]       cv = 10'h000;
	logic [7:0]       bdrv = 8'h00;
	logic [7:0]       bval = 8'h00;
	wire logic [7:0]  pad_in;
	logic [7:0]       pad_out;
	logic [7:0]       pad_oe;
	wire logic [10:0] core_in;
	logic [5:0]       sh [8];
	logic [31:0]      seed = 32'h723e;
	logic [31:0]      q;
	int               fail_count = 0;
	int               checks = 0;

	always #2 ref_clk = ~ref_clk;

	pin_function_mux_power_gating dut_u (
		.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.main_power_good_in(pg), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .host_power_down_pad_in(hp_pad),
		.host_power_down_n(core_in[0]), .led0_out(cv[0]),
		.test_clk_out(cv[1]), .smbus_port0_data_drive(cv[2]),
		.smbus_port0_data_low_volt_drive(cv[3]),
		.smbus_port0_data(core_in[10]),
		.smbus_port0_data_low_volt(core_in[9]),
		.kbd_scan_input_2(core_in[8]), .smbus_port0_clock_drive(cv[4]),
		.smbus_port0_clock_low_volt_drive(cv[5]),
		.smbus_port0_clock(core_in[7]),
		.smbus_port0_clock_low_volt(core_in[6]),
		.kbd_scan_input_3(core_in[5]), .external_reset_input_n(core_in[4]),
		.kbd_scan_output_3(cv[6]), .private_flash_data0_out(cv[7]),
		.private_flash_data0_oe(cv[8]), .private_flash_data0(core_in[3]),
		.fan_tach_0(core_in[2]), .pwm_0(cv[9]),
		.uart_baud_clock(core_in[1])
	);

	pad_board_model board_u (
		.pad_out(pad_out), .pad_oe(pad_oe), .board_drive(bdrv),
		.board_level(bval), .pad_level(pad_in)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// selected and powered: pad level, otherwise the gated level
	function automatic logic gin(input int i, input logic [1:0] s,
		input logic g);
		if (sh[i][1:0] == s && !(sh[i][2] && !pg))
			return pad_in[i];
		return g;
	endfunction

	function automatic logic [10:0] exp_core();
		return {gin(1, 2'h1, 1'h1), gin(1, 2'h2, 1'h1), gin(1, 2'h3, 1'h0),
			gin(2, 2'h1, 1'h1), gin(2, 2'h2, 1'h1), gin(2, 2'h3, 1'h0),
			gin(3, 2'h1, 1'h1), gin(4, 2'h2, 1'h0), gin(5, 2'h1, 1'h0),
			gin(7, 2'h2, 1'h0), pg ? hp_pad : 1'h1};
	endfunction

	// returns {enable, level}; smbus lines only ever pull low
	function automatic logic [1:0] exp_pad(input int i);
		logic [5:0] c;
		logic [1:0] r;
		c = sh[i];
		case ({i[2:0], c[1:0]})
			5'h01: r = {1'h1, cv[0]};
			5'h02: r = {1'h1, cv[1]};
			5'h05: r = {cv[2], 1'h0};
			5'h06: r = {cv[3], 1'h0};
			5'h09: r = {cv[4], 1'h0};
			5'h0a: r = {cv[5], 1'h0};
			5'h11: r = {1'h1, cv[6]};
			5'h12: r = {cv[8], cv[7]};
			5'h19: r = {1'h1, cv[9]};
			default: r = 2'h0;
		endcase
		if (c[1:0] == 2'h0)
			r = {c[3] & ~(c[4] & c[5]), c[5] & ~c[4]};
		r[1] = r[1] & ~(c[2] & ~pg);
		return r;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// waits on waitrequest, never on a fixed count
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		// only the watchdog ends a wait that never gets its answer
		do
		begin
			@(posedge ref_clk);
		end
		while (waitrequest !== 1'h0);
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (wr && be[0] && a < 8'h20 && a[1:0] == 2'h0)
			sh[a[4:2]] = d[5:0];
	endtask

	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	task automatic rb(input int i);
		bus(1'h0, 8'(i * 4), 32'h0, 4'hf);
		chk(q, {23'h0, pad_in[i], 2'h0, sh[i]});
	endtask

	task automatic check_all();
		logic [7:0] eo;
		logic [7:0] ev;
		logic [1:0] r;
		for (int j = 0; j < 8; j++)
		begin
			r = exp_pad(j);
			eo[j] = r[1];
			ev[j] = r[0];
		end
		chk({24'h0, pad_oe}, {24'h0, eo});
		chk({24'h0, pad_out & eo}, {24'h0, ev & eo});
		chk({21'h0, core_in}, {21'h0, exp_core()});
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		rst <= 1'h1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		for (int j = 0; j < 8; j++)
			sh[j] = (j == 3) ? 6'h01 : 6'h00;
		settle();
		check_all();
		for (int j = 0; j < 8; j++)
			rb(j);
		$display("test reset done");
	endtask

	task automatic final_report();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		final_report();
	end

	initial
	begin
		logic [2:0] pin;
		logic [5:0] c;
		do_reset();
		// refused writes: lane 0 off, status word; unmapped read is zero
		bus(1'h1, 8'h00, 32'h28, 4'he);
		bus(1'h1, 8'h40, 32'h0, 4'hf);
		bus(1'h0, 8'h44, 32'h0, 4'hf);
		chk(q, 32'h0);
		bus(1'h0, 8'h40, 32'h0, 4'hf);
		chk(q, {31'h0, pg});
		rb(0);
		$display("test registers done");
		// first 32 passes walk every select of every pin
		for (int k = 0; k < 96; k++)
		begin
			seed = xs(seed);
			pin = (k < 32) ? k[4:2] : seed[30:28];
			c = {seed[27:24], (k < 32) ? k[1:0] : seed[23:22]};
			@(posedge ref_clk);
			pg <= seed[8];
			hp_pad <= seed[9];
			cv <= seed[19:10];
			bdrv <= seed[7:0] & {8{seed[21]}};
			bval <= seed[31:24];
			bus(1'h1, {3'h0, pin, 2'h0}, {26'h0, c}, 4'h1);
			settle();
			check_all();
			rb(int'(pin));
		end
		$display("test random mux done");
		do_reset();
		final_report();
	end
endmodule
